/* File: hw/cbm_pkg.sv */
// constants, types and carriers for the console button, mute and headphone control
package cbm_pkg;

  // clock and timing
  localparam int CBM_CLK_HZ = 50_000_000;
  localparam int CBM_DEBOUNCE_US = 10_000; // button settle time
  localparam int CBM_HOLD_US = 400_000; // press at least this long is a hold, shorter is a tap
  localparam int CBM_BOOT_STEP_US = 250_000; // time each status led stays lit at power-up
  localparam int CBM_DEBOUNCE_CYC = CBM_DEBOUNCE_US * (CBM_CLK_HZ / 1_000_000);
  localparam int CBM_HOLD_CYC = CBM_HOLD_US * (CBM_CLK_HZ / 1_000_000);
  localparam int CBM_BOOT_STEP_CYC = CBM_BOOT_STEP_US * (CBM_CLK_HZ / 1_000_000);
  localparam int CBM_CNT_W = 26;

  // rotary control and gain code layout
  localparam int CBM_POT_W = 8;
  localparam logic [CBM_POT_W-1:0] CBM_POT_MAX = 8'hff; // fully clockwise
  localparam logic [CBM_POT_W-1:0] CBM_POT_HALF = 8'h80; // detent
  localparam logic [CBM_POT_W-1:0] CBM_GAIN_FLOOR = 8'h00; // 40 dB below maximum

  // button index in the button vectors
  localparam int CBM_BTN_MAIN = 0;
  localparam int CBM_BTN_TALK = 1;

  typedef logic [CBM_CNT_W-1:0] cbm_cnt_type;
  typedef logic [CBM_POT_W-1:0] cbm_pot_type;
  typedef logic [2*CBM_POT_W-1:0] cbm_wide_type;

  typedef enum logic [1:0] {CBM_PUSH_MUTE, CBM_PUSH_TALK, CBM_ALTERNATE, CBM_HYBRID} cbm_main_mode_type;
  typedef enum logic [1:0] {CBM_BOOT_MAIN_GREEN, CBM_BOOT_MAIN_RED, CBM_BOOT_TALK, CBM_RUN} cbm_boot_type;

  // configuration settings
  typedef struct packed {
    cbm_main_mode_type main_mode;
    logic talk_hybrid; // 1: talkback hybrid, 0: push to talk
    logic level_balance; // 1: level/balance, 0: level/level
    logic reverse; // swap left/right
    logic full_mute; // 1: fully ccw mutes, 0: 40 dB floor
    logic on_air; // 1: on-air system mode, 0: production
  } cbm_cfg_type;

  typedef struct packed {
    logic main_green;
    logic main_red;
    logic talk_green;
  } cbm_led_type;

  typedef struct packed {
    cbm_pot_type left_gain;
    cbm_pot_type right_gain;
    logic left_mute;
    logic right_mute;
  } cbm_hp_type;

  // whole state of the control block
  typedef struct packed {
    cbm_boot_type boot;
    cbm_cnt_type boot_cnt;
    cbm_cnt_type [1:0] db_cnt;
    logic [1:0] stable;
    cbm_cnt_type [1:0] press_cnt;
    logic main_latch;
    logic talk_latch;
    logic main_out;
    logic talk_out;
    cbm_led_type led;
    cbm_hp_type hp;
  } cbm_state_type;

endpackage

/* File: hw/cbm_console_ctrl.sv */
// button, mute, status led and headphone gain control of the announcer console
`timescale 1ns/1ps

// How it works
// - at power-up light the three status leds in turn, then run
// - main green led lit whenever main output active
// - on-air mode: once running, main red led lit whenever main output muted
// - production mode: main red led dark once running (lit only in its power-up phase)
// - push-to-mute: main active, muted only while button held
// - push-to-talk: main muted, active only while button held
// - alternate action: each press toggles main; starts muted
// - hybrid: hold gives active until release, tap toggles; starts muted
// - on-air mode: active talkback forces main output muted
// - on-air latched main output resumes after talkback ends
// - production mode: talkback does not affect main output
// - talkback green led lit whenever talkback active
// - talkback push-to-talk: active only while button held
// - talkback hybrid: hold active until release, tap toggles
// - talkback hybrid starts muted after power-up
// - level/level: left pot left channel, right pot right; reverse swaps
// - level/level floor: fully ccw gives 40 dB below maximum
// - level/level full mute: fully ccw mutes its channel
// - level/balance: left pot overall level, right pot balance
// - balance ccw lowers right normally, left when reversed
// - level/balance floor: level ccw or balance extreme holds 40 dB down
// - level/balance full mute: level ccw mutes both, extreme mutes one
// - one setting picks on-air or production system mode
module cbm_console_ctrl #(
  parameter int DEBOUNCE_CYC = cbm_pkg::CBM_DEBOUNCE_CYC,
  parameter int HOLD_CYC = cbm_pkg::CBM_HOLD_CYC,
  parameter int BOOT_STEP_CYC = cbm_pkg::CBM_BOOT_STEP_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic main_output_button, // high while pressed
  input wire logic talkback_button, // high while pressed
  input wire cbm_pkg::cbm_cfg_type cfg,
  input wire cbm_pkg::cbm_pot_type left_pot,
  input wire cbm_pkg::cbm_pot_type right_pot,
  output cbm_pkg::cbm_led_type leds,
  output logic main_active,
  output logic talkback_active,
  output cbm_pkg::cbm_hp_type hp
);

  localparam cbm_pkg::cbm_cnt_type DB_LAST = cbm_pkg::cbm_cnt_type'(DEBOUNCE_CYC - 1);
  localparam cbm_pkg::cbm_cnt_type HOLD_LIM = cbm_pkg::cbm_cnt_type'(HOLD_CYC);
  localparam cbm_pkg::cbm_cnt_type BOOT_LAST = cbm_pkg::cbm_cnt_type'(BOOT_STEP_CYC - 1);

  cbm_pkg::cbm_state_type q;
  cbm_pkg::cbm_state_type d;
  logic [1:0] btn;

  assign btn = {talkback_button, main_output_button};

  ////////////////////////////////////////////////////////////////////////////
  // headphone gain mapping

  // scale a level by a balance factor, full by full gives full
  function automatic cbm_pkg::cbm_pot_type scale(input cbm_pkg::cbm_pot_type lvl, input cbm_pkg::cbm_pot_type fac);
    cbm_pkg::cbm_wide_type prod;
    prod = cbm_pkg::cbm_wide_type'(lvl) * cbm_pkg::cbm_wide_type'(fac) + cbm_pkg::cbm_wide_type'(lvl);
    scale = prod[2*cbm_pkg::CBM_POT_W-1:cbm_pkg::CBM_POT_W];
  endfunction

  // pot positions and settings to per-channel gain and mute
  function automatic cbm_pkg::cbm_hp_type hp_map(input cbm_pkg::cbm_cfg_type c, input cbm_pkg::cbm_pot_type lp,
                                                 input cbm_pkg::cbm_pot_type rp);
    cbm_pkg::cbm_hp_type r;
    cbm_pkg::cbm_pot_type lo_fac;
    cbm_pkg::cbm_pot_type hi_fac;
    cbm_pkg::cbm_pot_type span;
    logic floor_l;
    logic floor_r;
    r = '0;
    span = cbm_pkg::CBM_POT_MAX - rp;
    // ccw half of balance trims one side, cw half the other
    lo_fac = (rp < cbm_pkg::CBM_POT_HALF) ? {rp[cbm_pkg::CBM_POT_W-2:0], 1'b0} : cbm_pkg::CBM_POT_MAX;
    hi_fac = (rp > cbm_pkg::CBM_POT_HALF) ? {span[cbm_pkg::CBM_POT_W-2:0], 1'b0} : cbm_pkg::CBM_POT_MAX;
    if (!c.level_balance) begin
      r.left_gain = c.reverse ? rp : lp;
      r.right_gain = c.reverse ? lp : rp;
      floor_l = (r.left_gain == '0);
      floor_r = (r.right_gain == '0);
    end else begin
      r.left_gain = scale(lp, c.reverse ? lo_fac : hi_fac);
      r.right_gain = scale(lp, c.reverse ? hi_fac : lo_fac);
      floor_l = (lp == '0) || (c.reverse ? (rp == '0) : (rp == cbm_pkg::CBM_POT_MAX));
      floor_r = (lp == '0) || (c.reverse ? (rp == cbm_pkg::CBM_POT_MAX) : (rp == '0));
    end
    // fully ccw or balance extreme: floor code or full mute
    if (floor_l) begin
      r.left_gain = cbm_pkg::CBM_GAIN_FLOOR;
      r.left_mute = c.full_mute;
    end
    if (floor_r) begin
      r.right_gain = cbm_pkg::CBM_GAIN_FLOOR;
      r.right_mute = c.full_mute;
    end
    hp_map = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // debounce, boot sequence, button modes, interlock, leds
  always_comb begin
    logic [1:0] rise;
    logic [1:0] tap;
    logic main_raw;
    logic talk_raw;
    logic run;
    rise = '0;
    tap = '0;
    main_raw = 1'b0;
    talk_raw = 1'b0;
    run = 1'b0;
    d = q;
    for (int i = 0; i < 2; i++) begin
      // stable level changes only after the input differs for the full settle time
      if (btn[i] == q.stable[i]) begin
        d.db_cnt[i] = '0;
      end else if (q.db_cnt[i] == DB_LAST) begin
        d.stable[i] = btn[i];
        d.db_cnt[i] = '0;
      end else begin
        d.db_cnt[i] = q.db_cnt[i] + cbm_pkg::cbm_cnt_type'(1);
      end
      // press length, saturating at the hold threshold
      if (!q.stable[i]) begin
        d.press_cnt[i] = '0;
      end else if (q.press_cnt[i] < HOLD_LIM) begin
        d.press_cnt[i] = q.press_cnt[i] + cbm_pkg::cbm_cnt_type'(1);
      end
      rise[i] = d.stable[i] & ~q.stable[i];
      tap[i] = ~d.stable[i] & q.stable[i] & (q.press_cnt[i] < HOLD_LIM);
    end
    // power-up led walk
    unique case (q.boot)
      cbm_pkg::CBM_BOOT_MAIN_GREEN, cbm_pkg::CBM_BOOT_MAIN_RED, cbm_pkg::CBM_BOOT_TALK: begin
        if (q.boot_cnt == BOOT_LAST) begin
          d.boot_cnt = '0;
          d.boot = cbm_pkg::cbm_boot_type'(q.boot + 2'd1);
        end else begin
          d.boot_cnt = q.boot_cnt + cbm_pkg::cbm_cnt_type'(1);
        end
      end
      cbm_pkg::CBM_RUN: begin
        d.boot_cnt = '0;
      end
    endcase
    run = (q.boot == cbm_pkg::CBM_RUN);
    // latches change only in normal operation; talkback leaves main latch untouched
    if (run) begin
      if (cfg.main_mode == cbm_pkg::CBM_ALTERNATE && rise[cbm_pkg::CBM_BTN_MAIN]) begin
        d.main_latch = ~q.main_latch;
      end
      if (cfg.main_mode == cbm_pkg::CBM_HYBRID && tap[cbm_pkg::CBM_BTN_MAIN]) begin
        d.main_latch = ~q.main_latch;
      end
      if (cfg.talk_hybrid && tap[cbm_pkg::CBM_BTN_TALK]) begin
        d.talk_latch = ~q.talk_latch;
      end
    end
    unique case (cfg.main_mode)
      cbm_pkg::CBM_PUSH_MUTE: main_raw = ~d.stable[cbm_pkg::CBM_BTN_MAIN];
      cbm_pkg::CBM_PUSH_TALK: main_raw = d.stable[cbm_pkg::CBM_BTN_MAIN];
      cbm_pkg::CBM_ALTERNATE: main_raw = d.main_latch;
      cbm_pkg::CBM_HYBRID: main_raw = d.main_latch | d.stable[cbm_pkg::CBM_BTN_MAIN];
    endcase
    talk_raw = cfg.talk_hybrid ? (d.talk_latch | d.stable[cbm_pkg::CBM_BTN_TALK])
                               : d.stable[cbm_pkg::CBM_BTN_TALK];
    d.talk_out = run & talk_raw;
    d.main_out = run & main_raw & ~(cfg.on_air & d.talk_out);
    // status leds
    if (!run) begin
      d.led.main_green = (q.boot == cbm_pkg::CBM_BOOT_MAIN_GREEN);
      d.led.main_red = (q.boot == cbm_pkg::CBM_BOOT_MAIN_RED);
      d.led.talk_green = (q.boot == cbm_pkg::CBM_BOOT_TALK);
    end else begin
      d.led.main_green = d.main_out;
      d.led.main_red = cfg.on_air & ~d.main_out;
      d.led.talk_green = d.talk_out;
    end
    d.hp = hp_map(cfg, left_pot, right_pot);
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign leds = q.led;
  assign main_active = q.main_out;
  assign talkback_active = q.talk_out;
  assign hp = q.hp;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_boot_onehot: assert property ((q.boot != cbm_pkg::CBM_RUN) |=> $onehot(leds))
    else $error("boot walk does not light exactly one led");
  a_green_main: assert property ((q.boot == cbm_pkg::CBM_RUN) |-> (leds.main_green == main_active))
    else $error("main green led does not follow main output");
  a_red_prod: assert property ((q.boot == cbm_pkg::CBM_RUN && !cfg.on_air) |=> !leds.main_red)
    else $error("red led lit in production mode");
  a_red_onair: assert property ((q.boot == cbm_pkg::CBM_RUN && $past(q.boot) == cbm_pkg::CBM_RUN
                                 && cfg.on_air && $past(cfg.on_air))
                                |-> (leds.main_red == !main_active))
    else $error("red led wrong in on-air mode");
  a_talk_interlock: assert property ((q.boot == cbm_pkg::CBM_RUN && cfg.on_air && $past(cfg.on_air)
                                      && talkback_active) |-> !main_active)
    else $error("main output active during talkback in on-air mode");
  a_main_ptt: assert property ((q.boot == cbm_pkg::CBM_RUN && cfg.main_mode == cbm_pkg::CBM_PUSH_TALK
                                && !cfg.on_air) |=> (main_active == q.stable[cbm_pkg::CBM_BTN_MAIN]))
    else $error("push to talk main output does not follow button");
  a_main_ptm: assert property ((q.boot == cbm_pkg::CBM_RUN && cfg.main_mode == cbm_pkg::CBM_PUSH_MUTE
                                && !cfg.on_air) |=> (main_active != q.stable[cbm_pkg::CBM_BTN_MAIN]))
    else $error("push to mute main output does not follow button");
  a_debounce_wait: assert property ($changed(q.stable[cbm_pkg::CBM_BTN_MAIN])
                                    |-> ($past(q.db_cnt[cbm_pkg::CBM_BTN_MAIN]) == DB_LAST))
    else $error("main button level changed before settle time");
  a_hybrid_tap: assert property ((q.boot == cbm_pkg::CBM_RUN && cfg.main_mode == cbm_pkg::CBM_HYBRID
                                  && q.stable[0] && !btn[0] && q.db_cnt[0] == DB_LAST && q.press_cnt[0] < HOLD_LIM)
                                 |=> (q.main_latch != $past(q.main_latch)))
    else $error("tap did not toggle hybrid main latch");
  a_talk_ptt: assert property ((q.boot == cbm_pkg::CBM_RUN && !cfg.talk_hybrid)
                               |=> (talkback_active == q.stable[cbm_pkg::CBM_BTN_TALK]))
    else $error("push to talk talkback does not follow button");
  a_floor_level: assert property ((!cfg.level_balance && !cfg.full_mute && !cfg.reverse && left_pot == '0)
                                  |=> (hp.left_gain == cbm_pkg::CBM_GAIN_FLOOR && !hp.left_mute))
    else $error("level floor not applied to left channel");
  a_mute_balance: assert property ((cfg.level_balance && cfg.full_mute && left_pot == '0)
                                   |=> (hp.left_mute && hp.right_mute))
    else $error("level fully ccw did not mute both channels");

endmodule // cbm_console_ctrl

/* File: test/cbm_operator.sv */
// behavioural operator: presses the two buttons with contact bounce
`timescale 1ns/1ps
module cbm_operator (
  input wire logic ref_clk,
  input wire logic [1:0] req,
  output logic main_output_button,
  output logic talkback_button
);
  logic [1:0] last_q = 2'b00;
  logic [1:0] btn_q = 2'b00;
  logic [1:0] bounce_q [2] = '{2'd0, 2'd0};

  // each change of a requested level chatters for three cycles before it settles
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (req[i] !== last_q[i]) begin
        bounce_q[i] <= 2'd3;
      end else if (bounce_q[i] != 2'd0) begin
        bounce_q[i] <= bounce_q[i] - 2'd1;
      end
      last_q[i] <= req[i];
      btn_q[i] <= (bounce_q[i] != 2'd0) ? ~btn_q[i] : req[i];
    end
  end

  assign main_output_button = btn_q[0];
  assign talkback_button = btn_q[1];
endmodule // cbm_operator

/* File: test/tb_cbm_console_ctrl.sv */
// self-checking bench of the console button, mute and headphone control
`timescale 1ns/1ps
module tb_cbm_console_ctrl;
  localparam int STEP = 8;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] req = 2'b00;
  cbm_pkg::cbm_cfg_type cfg = '0;
  cbm_pkg::cbm_pot_type left_pot = 8'h00;
  cbm_pkg::cbm_pot_type right_pot = 8'h00;
  logic main_output_button;
  logic talkback_button;
  cbm_pkg::cbm_led_type leds;
  logic main_active;
  logic talkback_active;
  cbm_pkg::cbm_hp_type hp;
  int err_total = 0;
  int comparisons = 0;
  integer seed = 32'hc358_2238;
  logic [7:0] corner [4] = '{8'h00, 8'hff, 8'h80, 8'h01};

  always #10 ref_clk = ~ref_clk;

  cbm_operator cbm_operator_i (.ref_clk(ref_clk), .req(req), .main_output_button(main_output_button),
    .talkback_button(talkback_button));
  cbm_console_ctrl #(.DEBOUNCE_CYC(4), .HOLD_CYC(20), .BOOT_STEP_CYC(STEP)) cbm_console_ctrl_i (
    .ref_clk(ref_clk), .rst(rst), .main_output_button(main_output_button), .talkback_button(talkback_button),
    .cfg(cfg), .left_pot(left_pot), .right_pot(right_pot), .leds(leds), .main_active(main_active),
    .talkback_active(talkback_active), .hp(hp));

  ////////////////////////////////////////////////////////////////
  // expected headphone gains and mutes
  function automatic cbm_pkg::cbm_hp_type exp_hp(input cbm_pkg::cbm_cfg_type c, input logic [7:0] lp,
    input logic [7:0] rp);
    cbm_pkg::cbm_hp_type h;
    logic [7:0] t;
    logic [15:0] w;
    logic ma;
    logic mb;
    logic ex;
    h.left_gain = c.reverse ? rp : lp;
    h.right_gain = c.reverse ? lp : rp;
    ma = (h.left_gain == 8'h00);
    mb = (h.right_gain == 8'h00);
    if (c.level_balance) begin
      t = rp[7] ? ~rp : rp;
      w = 16'(lp) * 16'({t[6:0], 1'b0}) + 16'(lp);
      ex = (rp == 8'h00) || (rp == 8'hff);
      h.left_gain = lp;
      h.right_gain = lp;
      ma = (lp == 8'h00);
      mb = ma;
      if (rp != 8'h80 && (rp[7] ^ c.reverse)) begin
        h.left_gain = w[15:8];
        ma = ma | ex;
      end else if (rp != 8'h80) begin
        h.right_gain = w[15:8];
        mb = mb | ex;
      end
    end
    h.left_mute = c.full_mute & ma;
    h.right_mute = c.full_mute & mb;
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////
  // checking, stimulus and closing tasks
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // leds, main and talkback states in one word
  task automatic outs(input logic m, input logic t, input logic [2:0] l);
    check(32'({leds, main_active, talkback_active}), 32'({l, m, t}));
  endtask

  task automatic btn(input int b, input logic v);
    @(posedge ref_clk);
    req[b] <= v;
    cyc(12);
  endtask

  task automatic tap(input int b);
    btn(b, 1'b1);
    btn(b, 1'b0);
  endtask

  // one boot led phase: must appear, then last exactly one step
  task automatic boot_step(input logic [2:0] l);
    int n;
    n = 0;
    while (leds !== l && n < 40) begin
      cyc(1);
      n++;
    end
    outs(1'b0, 1'b0, l);
    n = 0;
    while (leds === l && n < 40) begin
      cyc(1);
      n++;
    end
    if (n == 40) begin
      err_total++;
      stop_test();
    end
    check(32'(n), 32'(STEP));
  endtask

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    cfg.main_mode = cbm_pkg::CBM_ALTERNATE;
    cfg.talk_hybrid = 1'b1;
    cfg.on_air = 1'b1;
    cyc(20);
    @(posedge ref_clk);
    rst <= 1'b0;
    boot_step(3'b100);
    boot_step(3'b010);
    boot_step(3'b001);
    cyc(2);
    outs(1'b0, 1'b0, 3'b010);
    tap(0);
    outs(1'b1, 1'b0, 3'b100);
    tap(1);
    outs(1'b0, 1'b1, 3'b011);
    tap(1);
    outs(1'b1, 1'b0, 3'b100);
    btn(1, 1'b1);
    cyc(30);
    outs(1'b0, 1'b1, 3'b011);
    btn(1, 1'b0);
    outs(1'b1, 1'b0, 3'b100);
    $display("test boot and on-air interlock done");
    @(posedge ref_clk);
    cfg.on_air <= 1'b0;
    cyc(3);
    tap(1);
    outs(1'b1, 1'b1, 3'b101);
    tap(0);
    outs(1'b0, 1'b1, 3'b001);
    tap(1);
    outs(1'b0, 1'b0, 3'b000);
    $display("test production mode done");
    @(posedge ref_clk);
    cfg.main_mode <= cbm_pkg::CBM_PUSH_MUTE;
    cfg.talk_hybrid <= 1'b0;
    cyc(3);
    outs(1'b1, 1'b0, 3'b100);
    btn(0, 1'b1);
    outs(1'b0, 1'b0, 3'b000);
    btn(0, 1'b0);
    @(posedge ref_clk);
    cfg.main_mode <= cbm_pkg::CBM_PUSH_TALK;
    cyc(3);
    outs(1'b0, 1'b0, 3'b000);
    btn(0, 1'b1);
    outs(1'b1, 1'b0, 3'b100);
    btn(0, 1'b0);
    btn(1, 1'b1);
    outs(1'b0, 1'b1, 3'b001);
    btn(1, 1'b0);
    outs(1'b0, 1'b0, 3'b000);
    @(posedge ref_clk);
    cfg.main_mode <= cbm_pkg::CBM_HYBRID;
    cyc(3);
    tap(0);
    outs(1'b1, 1'b0, 3'b100);
    tap(0);
    outs(1'b0, 1'b0, 3'b000);
    btn(0, 1'b1);
    cyc(30);
    outs(1'b1, 1'b0, 3'b100);
    btn(0, 1'b0);
    outs(1'b0, 1'b0, 3'b000);
    $display("test button modes done");
    for (int i = 0; i < 400; i++) begin
      @(posedge ref_clk);
      left_pot <= (i % 5 == 0) ? 8'h00 : 8'($random(seed));
      right_pot <= (i % 2 == 0) ? corner[(i / 2) % 4] : 8'($random(seed));
      cfg.level_balance <= 1'($random(seed));
      cfg.reverse <= 1'($random(seed));
      cfg.full_mute <= 1'($random(seed));
      cyc(2);
      check(32'(hp), 32'(exp_hp(cfg, left_pot, right_pot)));
    end
    $display("test headphone gains done");
    stop_test();
  end
endmodule // tb_cbm_console_ctrl
